//--- verilog/dcl_map.svh
// constants: offsets, field positions, reset values and timing counts
`ifndef DCL_MAP_SVH
`define DCL_MAP_SVH
// =====================================================================
// mode word selectors and field positions
`define DCL_MW_SRT      3'h2
`define DCL_MW_MPR      3'h3
`define DCL_MW_CAL      3'h4
`define DCL_MW_DBI      3'h5
`define DCL_SRT_HI      7
`define DCL_SRT_LO      6
`define DCL_FMT_HI      12
`define DCL_FMT_LO      11
`define DCL_MPR_EN_BIT  2
`define DCL_PAGE_HI     1
`define DCL_PAGE_LO     0
`define DCL_CAL_HI      8
`define DCL_CAL_LO      6
`define DCL_DBI_BIT     12
// =====================================================================
// field codes
`define DCL_SRT_NORM    2'h0
`define DCL_SRT_RED     2'h1
`define DCL_SRT_EXT     2'h2
`define DCL_SRT_AUTO    2'h3
`define DCL_FMT_SER     2'h0
`define DCL_FMT_PAR     2'h1
`define DCL_FMT_STAG    2'h2
`define DCL_PAGE_RSVD   2'h3
// =====================================================================
// pattern page reset values
`define DCL_PAT0        8'h55
`define DCL_PAT1        8'h33
`define DCL_PAT2        8'h0f
`define DCL_PAT3        8'h00
// =====================================================================
// timing
`define DCL_CAL_MAX     7
`define DCL_READ_LAT    5'h0b
`define DCL_BURST       5'h08
`define DCL_MOD_CYC     6'h18
`define DCL_CLK_NS      40
`define DCL_RFC_NS      260
`define DCL_RFC_CYC     (((`DCL_RFC_NS) + (`DCL_CLK_NS) - 1) / (`DCL_CLK_NS))
`define DCL_HALF_ZEROS  4'h4
// =====================================================================
// controller register offsets
`define DCL_REG_REQ     8'h00
`define DCL_REG_WDATA   8'h04
`define DCL_REG_STAT    8'h08
`define DCL_REG_RDLO    8'h0c
`define DCL_REG_RDHI    8'h10
`define DCL_REG_ODT     8'h14
`define DCL_REQ_ADDR_LO 16
`endif

//--- verilog/dcl_pkg.sv
// shared types of the command-side mode logic
package dcl_pkg;
	// =================================================================
	// command codes on the command bus
	typedef enum logic [3:0] {
		DCL_DES, DCL_MRS, DCL_REF, DCL_SRE, DCL_SRX, DCL_PDE, DCL_PDX,
		DCL_ACT, DCL_PRE, DCL_RD, DCL_RDA, DCL_WR, DCL_WRA, DCL_RST
	} dcl_cmd_t;
	// controller sequencer states
	typedef enum logic [1:0] {DCL_IDLE, DCL_LEAD, DCL_GAP} dcl_seq_t;
endpackage

//--- verilog/dcl_if.sv
// command/address and read-data link between controller and dram end
interface dcl_if;
	logic       cs_n;
	logic [3:0] cmd;
	logic [2:0] ba;
	logic [13:0] addr;
	logic [7:0] wdata;
	logic       odt;
	logic [7:0] rdata;
	logic       rvalid;
	logic       dbi_n;
	modport dev (input cs_n, cmd, ba, addr, wdata, odt, output rdata, rvalid, dbi_n);
	modport ctl (output cs_n, cmd, ba, addr, wdata, odt, input rdata, rvalid, dbi_n);
endinterface

//--- verilog/dcl_dram_end.sv
// dram end: latency gating, self-refresh mode and pattern store
`include "dcl_map.svh"

module dcl_dram_end (
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// link to the controller
	dcl_if.dev              bus,
	// temperature sense pins
	input  wire logic       temp_hot_pin,
	input  wire logic       temp_cold_pin,
	// status
	output logic [1:0]      sr_rate,
	output logic            in_selfref,
	output logic            rx_on,
	output logic            term_on,
	output logic            mpr_on
);
	// =================================================================
	// state
	logic [`DCL_CAL_MAX-1:0] cs_pipe_reg;
	logic [2:0]  cal_reg;
	logic [1:0]  srt_reg;
	logic [1:0]  sr_mode_reg;
	logic [1:0]  fmt_reg;
	logic [1:0]  page_reg;
	logic        dbi_en_reg;
	logic        hot_s1, hot_s2, cold_s1, cold_s2;
	logic [7:0]  mem [0:15];
	logic        rd_busy_reg;
	logic        rd_mpr_reg;
	logic [4:0]  rd_cnt_reg;
	logic [1:0]  rd_ba_reg;
	logic [1:0]  rd_page_reg;
	logic [1:0]  rd_fmt_reg;
	logic        cal_on, rx_live, take, cs_low;
	logic        is_rd, is_wr;
	logic [7:0]  beat_d;
	logic [2:0]  beat;
	dcl_pkg::dcl_cmd_t cmd_in;

	// =================================================================
	// functions
	// zeros in a byte, for the inversion decision
	function automatic logic [3:0] zeros(input logic [7:0] d);
		logic [3:0] n;
		n = 4'h0;
		for (int i = 0; i < 8; i++) begin
			n = n + {3'h0, ~d[i]};
		end
		return n;
	endfunction

	// =================================================================
	// command capture with optional select-to-command latency
	assign cs_low  = ~bus.cs_n;
	assign cal_on  = cal_reg != 3'h0;
	// command sampled cal_reg edges after select was seen low
	assign take    = cal_on ? cs_pipe_reg[cal_reg - 3'h1] : cs_low;
	// receivers always live with latency off; otherwise while select is low or was low in the last 7 cycles
	assign rx_live = ~cal_on | cs_low | (|cs_pipe_reg);
	assign cmd_in  = dcl_pkg::dcl_cmd_t'(bus.cmd);
	// auto-precharge variants decode the same way; no bank model here
	assign is_rd   = take & (cmd_in == dcl_pkg::DCL_RD || cmd_in == dcl_pkg::DCL_RDA);
	assign is_wr   = take & (cmd_in == dcl_pkg::DCL_WR || cmd_in == dcl_pkg::DCL_WRA);

	// select history, cleared when the option is off
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_pipe_reg <= '0;
		end else if (ce) begin
			cs_pipe_reg <= cal_on ? {cs_pipe_reg[`DCL_CAL_MAX-2:0], cs_low} : '0;
		end
	end

	// =================================================================
	// mode words
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_reg    <= 3'h0;
			srt_reg    <= `DCL_SRT_NORM;
			mpr_on     <= 1'b0;
			fmt_reg    <= `DCL_FMT_SER;
			page_reg   <= 2'h0;
			dbi_en_reg <= 1'b0;
		end else if (ce && take && cmd_in == dcl_pkg::DCL_MRS) begin
			unique case (bus.ba)
				`DCL_MW_SRT: srt_reg <= bus.addr[`DCL_SRT_HI:`DCL_SRT_LO];
				`DCL_MW_MPR: begin
					fmt_reg  <= bus.addr[`DCL_FMT_HI:`DCL_FMT_LO];
					mpr_on   <= bus.addr[`DCL_MPR_EN_BIT];
					page_reg <= bus.addr[`DCL_PAGE_HI:`DCL_PAGE_LO];
				end
				`DCL_MW_CAL: cal_reg <= bus.addr[`DCL_CAL_HI:`DCL_CAL_LO];
				`DCL_MW_DBI: dbi_en_reg <= bus.addr[`DCL_DBI_BIT];
				default: ;
			endcase
		end
	end

	// =================================================================
	// self refresh: manual mode frozen at entry
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_selfref  <= 1'b0;
			sr_mode_reg <= `DCL_SRT_NORM;
		end else if (ce && take) begin
			if (cmd_in == dcl_pkg::DCL_SRE) begin
				in_selfref  <= 1'b1;
				sr_mode_reg <= srt_reg;
			end else if (cmd_in == dcl_pkg::DCL_SRX) begin
				in_selfref  <= 1'b0;
			end
		end
	end

	// temperature pins come from outside; two stages before use
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{hot_s1, hot_s2, cold_s1, cold_s2} <= 4'h0;
		end else if (ce) begin
			hot_s1  <= temp_hot_pin;
			hot_s2  <= hot_s1;
			cold_s1 <= temp_cold_pin;
			cold_s2 <= cold_s1;
		end
	end

	// refresh rate in use; hot wins over cold if both are claimed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sr_rate <= `DCL_SRT_NORM;
		end else if (ce) begin
			if (!in_selfref)
				sr_rate <= `DCL_SRT_NORM;
			else if (sr_mode_reg != `DCL_SRT_AUTO)
				sr_rate <= sr_mode_reg;
			else if (hot_s2)
				sr_rate <= `DCL_SRT_EXT;
			else if (cold_s2)
				sr_rate <= `DCL_SRT_RED;
			else
				sr_rate <= `DCL_SRT_NORM;
		end
	end

	// =================================================================
	// pattern store: page 0 writable, pages 1-3 read only, 3 reserved
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 16; i++) begin
				mem[i] <= 8'h00;
			end
			mem[0] <= `DCL_PAT0;
			mem[1] <= `DCL_PAT1;
			mem[2] <= `DCL_PAT2;
			mem[3] <= `DCL_PAT3;
		end else if (ce && is_wr && mpr_on && page_reg == 2'h0) begin
			mem[{2'h0, bus.ba[1:0]}] <= bus.wdata;
		end
	end

	// =================================================================
	// read pipeline, shared by ordinary and store reads
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_busy_reg <= 1'b0;
			rd_cnt_reg  <= 5'h0;
			rd_mpr_reg  <= 1'b0;
			rd_ba_reg   <= 2'h0;
			rd_page_reg <= 2'h0;
			rd_fmt_reg  <= `DCL_FMT_SER;
		end else if (ce) begin
			if (is_rd && !rd_busy_reg) begin
				rd_busy_reg <= 1'b1;
				rd_cnt_reg  <= 5'h1;
				rd_mpr_reg  <= mpr_on;
				rd_ba_reg   <= bus.ba[1:0];
				rd_page_reg <= page_reg;
				// other pages fall back to serial readout
				rd_fmt_reg  <= (page_reg == 2'h0) ? fmt_reg : `DCL_FMT_SER;
			end else if (rd_busy_reg) begin
				rd_cnt_reg  <= rd_cnt_reg + 5'h1;
				if (rd_cnt_reg == `DCL_READ_LAT + `DCL_BURST - 5'h1)
					rd_busy_reg <= 1'b0;
			end
		end
	end

	// beat data by readout format; main array is not modelled (zeros)
	assign beat = 3'(rd_cnt_reg - `DCL_READ_LAT);
	always_comb begin
		beat_d = 8'h00;
		if (rd_mpr_reg && rd_page_reg != `DCL_PAGE_RSVD) begin
			unique case (rd_fmt_reg)
				`DCL_FMT_PAR: beat_d = mem[{rd_page_reg, rd_ba_reg}];
				`DCL_FMT_STAG: begin
					for (int j = 0; j < 8; j++) begin
						beat_d[j] = mem[{rd_page_reg, 2'(rd_ba_reg + 2'(j))}][3'h7 - beat];
					end
				end
				default: beat_d = {8{mem[{rd_page_reg, rd_ba_reg}][3'h7 - beat]}};
			endcase
		end
	end

	// registered read outputs; inversion only outside store mode
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bus.rvalid <= 1'b0;
			bus.rdata  <= 8'h00;
			bus.dbi_n  <= 1'b1;
		end else if (ce) begin
			bus.rvalid <= rd_busy_reg && rd_cnt_reg >= `DCL_READ_LAT;
			if (dbi_en_reg && !rd_mpr_reg && zeros(beat_d) > `DCL_HALF_ZEROS) begin
				bus.rdata <= ~beat_d;
				bus.dbi_n <= 1'b0;
			end else begin
				bus.rdata <= beat_d;
				bus.dbi_n <= 1'b1;
			end
		end
	end

	// =================================================================
	// receiver and termination status; termination never goes through
	// the latency pipe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rx_on   <= 1'b1;
			term_on <= 1'b0;
		end else if (ce) begin
			rx_on   <= rx_live;
			term_on <= bus.odt;
		end
	end
endmodule

//--- verilog/dcl_ctl_end.sv
// controller end: apb registers, command sequencing and spacing
`include "dcl_map.svh"

module dcl_ctl_end (
	// clock, reset, enable
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// link to the dram end
	dcl_if.ctl               bus
);
	// =================================================================
	// state
	dcl_pkg::dcl_seq_t  st_reg;
	dcl_pkg::dcl_cmd_t  req_cmd;
	logic [5:0]  cnt_reg;
	logic [2:0]  cal_sh_reg;
	logic        mpr_sh_reg, sr_sh_reg, dbi_sh_reg;
	logic        rej_reg;
	logic [7:0]  wdata_reg;
	logic [63:0] rbuf_reg;
	logic [31:0] last_req_reg;
	logic        wr_go, req_go, bad, rej_clr;
	logic [2:0]  new_cal;
	logic [31:0] go_req;

	assign wr_go   = psel && penable && pready && pwrite;
	assign req_go  = wr_go && paddr == `DCL_REG_REQ;
	assign rej_clr = wr_go && paddr == `DCL_REG_STAT && pwdata[1];
	assign req_cmd = dcl_pkg::dcl_cmd_t'(pwdata[3:0]);
	// order whose command goes out now: fresh when idle, stored while leading
	assign go_req  = (st_reg == dcl_pkg::DCL_IDLE) ? pwdata : last_req_reg;
	assign new_cal = pwdata[`DCL_REQ_ADDR_LO + `DCL_CAL_HI:`DCL_REQ_ADDR_LO + `DCL_CAL_LO];

	// =================================================================
	// request screening
	always_comb begin
		bad = st_reg != dcl_pkg::DCL_IDLE;
		// store mode admits a short list only
		if (mpr_sh_reg && !(req_cmd inside {dcl_pkg::DCL_MRS, dcl_pkg::DCL_RD,
				dcl_pkg::DCL_RDA, dcl_pkg::DCL_WR, dcl_pkg::DCL_WRA,
				dcl_pkg::DCL_DES, dcl_pkg::DCL_REF, dcl_pkg::DCL_RST}))
			bad = 1'b1;
		if (req_cmd == dcl_pkg::DCL_MRS && pwdata[6:4] == `DCL_MW_SRT && sr_sh_reg)
			bad = 1'b1;
		if (req_cmd == dcl_pkg::DCL_MRS && pwdata[6:4] == `DCL_MW_MPR && dbi_sh_reg
				&& pwdata[`DCL_REQ_ADDR_LO + `DCL_MPR_EN_BIT])
			bad = 1'b1;
	end

	// =================================================================
	// apb slave: one wait state, then answer for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else if (ce) begin
			pready  <= psel && penable && !pready;
			pslverr <= 1'b0;
			if (psel && penable && !pready) begin
				pslverr <= paddr > `DCL_REG_ODT || paddr[1:0] != 2'h0;
				unique case (paddr)
					`DCL_REG_REQ:   prdata <= last_req_reg;
					`DCL_REG_WDATA: prdata <= {24'h0, wdata_reg};
					`DCL_REG_STAT:  prdata <= {25'h0, sr_sh_reg, mpr_sh_reg,
						cal_sh_reg, rej_reg, st_reg != dcl_pkg::DCL_IDLE};
					`DCL_REG_RDLO:  prdata <= rbuf_reg[31:0];
					`DCL_REG_RDHI:  prdata <= rbuf_reg[63:32];
					`DCL_REG_ODT:   prdata <= {31'h0, bus.odt};
					default:        prdata <= 32'h0;
				endcase
			end
		end
	end

	// plain registers; a refusal in the clearing cycle still sticks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wdata_reg    <= 8'h00;
			bus.odt      <= 1'b0;
			rej_reg      <= 1'b0;
			last_req_reg <= 32'h0;
		end else if (ce) begin
			if (wr_go && paddr == `DCL_REG_WDATA)
				wdata_reg <= pwdata[7:0];
			if (wr_go && paddr == `DCL_REG_ODT)
				bus.odt <= pwdata[0];
			if (req_go)
				last_req_reg <= pwdata;
			if (req_go && bad)
				rej_reg <= 1'b1;
			else if (rej_clr)
				rej_reg <= 1'b0;
		end
	end

	// =================================================================
	// sequencer: select lead, command, then enforced gap
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg    <= dcl_pkg::DCL_IDLE;
			cnt_reg   <= 6'h0;
			bus.cs_n  <= 1'b1;
			bus.cmd   <= dcl_pkg::DCL_DES;
			bus.ba    <= 3'h0;
			bus.addr  <= 14'h0;
			bus.wdata <= 8'h00;
		end else if (ce) begin
			bus.cs_n <= 1'b1;
			bus.cmd  <= dcl_pkg::DCL_DES;
			unique case (st_reg)
				dcl_pkg::DCL_IDLE: if (req_go && !bad) begin
					bus.cs_n  <= 1'b0;
					bus.ba    <= pwdata[6:4];
					bus.addr  <= pwdata[`DCL_REQ_ADDR_LO + 13:`DCL_REQ_ADDR_LO];
					bus.wdata <= wdata_reg;
					if (cal_sh_reg == 3'h0) begin
						bus.cmd <= req_cmd;
						st_reg  <= dcl_pkg::DCL_GAP;
					end else begin
						cnt_reg <= {3'h0, cal_sh_reg};
						st_reg  <= dcl_pkg::DCL_LEAD;
					end
				end
				dcl_pkg::DCL_LEAD: begin
					cnt_reg <= cnt_reg - 6'h1;
					if (cnt_reg == 6'h1) begin
						bus.cmd <= dcl_pkg::dcl_cmd_t'(last_req_reg[3:0]);
						st_reg  <= dcl_pkg::DCL_GAP;
					end
				end
				dcl_pkg::DCL_GAP: begin
					if (cnt_reg <= 6'h1)
						st_reg <= dcl_pkg::DCL_IDLE;
					cnt_reg <= cnt_reg - 6'h1;
				end
			endcase
			// gap length fixed at the cycle the command goes out
			if ((st_reg == dcl_pkg::DCL_IDLE && req_go && !bad && cal_sh_reg == 3'h0)
					|| (st_reg == dcl_pkg::DCL_LEAD && cnt_reg == 6'h1)) begin
				unique case (dcl_pkg::dcl_cmd_t'(go_req[3:0]))
					dcl_pkg::DCL_MRS: cnt_reg <= `DCL_MOD_CYC + {3'h0, mpr_cal_pick()};
					dcl_pkg::DCL_REF: cnt_reg <= 6'(`DCL_RFC_CYC);
					dcl_pkg::DCL_RD, dcl_pkg::DCL_RDA: cnt_reg <= 6'(`DCL_READ_LAT + `DCL_BURST);
					default: cnt_reg <= 6'h1;
				endcase
			end
		end
	end

	// latency that governs a mode-set gap: the new value if it changes
	function automatic logic [2:0] mpr_cal_pick();
		logic [31:0] r;
		r = go_req;
		if (r[6:4] == `DCL_MW_CAL)
			return r[`DCL_REQ_ADDR_LO + `DCL_CAL_HI:`DCL_REQ_ADDR_LO + `DCL_CAL_LO];
		return cal_sh_reg;
	endfunction

	// =================================================================
	// shadows of what the dram end was told
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			{cal_sh_reg, mpr_sh_reg, sr_sh_reg, dbi_sh_reg} <= 6'h0;
		end else if (ce && req_go && !bad) begin
			if (req_cmd == dcl_pkg::DCL_SRE)
				sr_sh_reg <= 1'b1;
			if (req_cmd == dcl_pkg::DCL_SRX)
				sr_sh_reg <= 1'b0;
			if (req_cmd == dcl_pkg::DCL_MRS) begin
				unique case (pwdata[6:4])
					`DCL_MW_CAL: cal_sh_reg <= new_cal;
					`DCL_MW_MPR: mpr_sh_reg <= pwdata[`DCL_REQ_ADDR_LO + `DCL_MPR_EN_BIT];
					`DCL_MW_DBI: dbi_sh_reg <= pwdata[`DCL_REQ_ADDR_LO + `DCL_DBI_BIT];
					default: ;
				endcase
			end
		end
	end

	// read beats, inversion undone, beat 0 ends in the low byte
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rbuf_reg <= 64'h0;
		end else if (ce && bus.rvalid) begin
			rbuf_reg <= {bus.dbi_n ? bus.rdata : ~bus.rdata, rbuf_reg[63:8]};
		end
	end
endmodule

//--- tb/dcl_checker.sv
// link checker: latency gating, spacing, read timing, store data
`include "dcl_map.svh"
module dcl_checker (
	// clock and reset
	input wire logic        clk,
	input wire logic        rst,
	// link signals
	input wire logic        cs_n,
	input wire logic [3:0]  cmd,
	input wire logic [2:0]  ba,
	input wire logic [13:0] addr,
	input wire logic [7:0]  rdata,
	input wire logic        rvalid,
	input wire logic        dbi_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       is_cmd;
	logic       is_rd;
	logic       is_mrs;
	logic [2:0] cal_q;
	logic       mpr_q;
	logic       ser_q;
	logic [1:0] page_q;
	logic [7:0] cs_hist;
	logic [5:0] since_q;
	logic [5:0] need_q;
	// =================================================================
	// command decode
	assign is_cmd = cmd != dcl_pkg::DCL_DES;
	assign is_rd  = cmd == dcl_pkg::DCL_RD || cmd == dcl_pkg::DCL_RDA;
	assign is_mrs = cmd == dcl_pkg::DCL_MRS;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// mirror of mode words; a refused order reaches the link only when written during a select lead, whose command it then replaces
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cal_q  <= 3'h0;
			mpr_q  <= 1'b0;
			ser_q  <= 1'b1;
			page_q <= 2'h0;
		end else if (is_mrs && ba == `DCL_MW_CAL) begin
			cal_q <= addr[8:6];
		end else if (is_mrs && ba == `DCL_MW_MPR) begin
			mpr_q  <= addr[2];
			page_q <= addr[1:0];
			ser_q  <= addr[1:0] != 2'h0 || addr[12:11] == 2'h0 || addr[12:11] == 2'h3;
		end
	end
	// select history, bit i = low i+1 cycles ago
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			cs_hist <= 8'h00;
		else
			cs_hist <= {cs_hist[6:0], ~cs_n};
	end
	// spacing owed, counted command to command so latency cancels out
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_q <= 6'h3f;
			need_q  <= 6'h00;
		end else if (is_cmd) begin
			since_q <= 6'h01;
			if (is_mrs)
				need_q <= 6'h18 + {3'h0, (ba == `DCL_MW_CAL) ? addr[8:6] : cal_q};
			else if (cmd == dcl_pkg::DCL_REF)
				need_q <= 6'h07;
			else if (is_rd)
				need_q <= 6'h13;
			else
				need_q <= 6'h01;
		end else if (since_q != 6'h3f) begin
			since_q <= since_q + 6'h01;
		end
	end
	// =================================================================
	// assertions
	AST_CS_TAKEN: assert property ((cal_q == 3'h0 && is_cmd) |-> !cs_n)
		else $error("command without select at zero latency");
	AST_CS_LEAD: assert property ((cal_q != 3'h0 && !cs_n) |-> !is_cmd)
		else $error("command beside select with latency on");
	AST_CAL_DELAY: assert property ((cal_q != 3'h0 && is_cmd) |-> cs_n && cs_hist[cal_q - 3'h1])
		else $error("command not at select plus latency");
	AST_CMD_GAP: assert property (is_cmd |-> since_q >= need_q)
		else $error("command spacing too short");
	AST_READ_BURST: assert property (is_rd |-> ##12 rvalid [*8] ##1 !rvalid)
		else $error("read burst timing wrong");
	AST_NO_STRAY: assert property ($rose(rvalid) |-> $past(is_rd, 12))
		else $error("read data without read");
	AST_STORE_DBI: assert property ((rvalid && mpr_q) |-> dbi_n)
		else $error("inversion on store read");
	AST_SERIAL: assert property ((rvalid && mpr_q && ser_q) |-> rdata == 8'h00 || rdata == 8'hff)
		else $error("serial beat lanes differ");
	AST_PAGE3: assert property ((rvalid && mpr_q && page_q == 2'h3) |-> rdata == 8'h00)
		else $error("reserved page not zero");
	// main scenarios
	COV_CAL_READ: cover property (is_rd && cal_q != 3'h0);
	COV_WIDE_READ: cover property (rvalid && mpr_q && !ser_q);
	COV_CAL_SET: cover property (is_mrs && ba == `DCL_MW_CAL);
endmodule

//--- tb/tb.sv
// bench: apb orders through the controller end, seen at the dram end
`include "dcl_map.svh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        temp_hot_pin, temp_cold_pin, in_selfref, rx_on, term_on, mpr_on;
	logic [1:0]  sr_rate;
	logic [7:0]  pat [4];
	int          num_errors, num_checks;
	dcl_if link ();
	// =================================================================
	// the two ends face each other; the checker watches the link
	dcl_ctl_end i_dcl_ctl_end (.clk(clk), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .bus(link));
	dcl_dram_end i_dcl_dram_end (.clk(clk), .rst(rst), .ce(ce), .bus(link),
		.temp_hot_pin(temp_hot_pin), .temp_cold_pin(temp_cold_pin), .sr_rate(sr_rate),
		.in_selfref(in_selfref), .rx_on(rx_on), .term_on(term_on), .mpr_on(mpr_on));
	dcl_checker i_dcl_checker (.clk(clk), .rst(rst), .cs_n(link.cs_n), .cmd(link.cmd),
		.ba(link.ba), .addr(link.addr), .rdata(link.rdata), .rvalid(link.rvalid),
		.dbi_n(link.dbi_n));
	// =================================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; answer taken at the edge that shows pready
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int n = 0; n < 50; n++) begin
			@(posedge clk);
			if (pready === 1'b1)
				break;
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		logic e;
		apb(1'b0, a, 32'h0, q, e);
	endtask
	// order a command, then poll busy so spacing is the controller's own
	task automatic issue(input dcl_pkg::dcl_cmd_t c, input logic [2:0] b, input logic [13:0] ad);
		logic [31:0] s;
		wr(`DCL_REG_REQ, {2'h0, ad, 9'h0, b, c});
		s = 32'h1;
		for (int n = 0; n < 40 && s[0] !== 1'b0; n++)
			rd(`DCL_REG_STAT, s);
	endtask
	// expected read word: four beats, beat 0 in the low byte
	function automatic logic [31:0] expw(input logic [1:0] f, input logic [1:0] pg,
			input logic [1:0] r, input logic hi);
		logic [31:0] w;
		int          bt;
		w = 32'h0;
		for (int k = 0; k < 4; k++) begin
			bt = hi ? k + 4 : k;
			for (int j = 0; j < 8; j++) begin
				if (pg == 2'h3)
					w[8*k+j] = 1'b0;
				else if (pg == 2'h0 && f == `DCL_FMT_PAR)
					w[8*k+j] = pat[r][j];
				else if (pg == 2'h0 && f == `DCL_FMT_STAG)
					w[8*k+j] = pat[(r+j)%4][7-bt];
				else
					w[8*k+j] = pat[r][7-bt];
			end
		end
		return w;
	endfunction
	task automatic t_read(input dcl_pkg::dcl_cmd_t c, input logic [1:0] f,
			input logic [1:0] pg, input logic [1:0] r);
		logic [31:0] q;
		issue(dcl_pkg::DCL_MRS, `DCL_MW_MPR, {1'b0, f, 8'h0, 1'b1, pg});
		chk("store mode", {31'h0, mpr_on}, 32'h1);
		issue(c, {1'b0, r}, 14'h0);
		rd(`DCL_REG_RDLO, q);
		chk("read low", q, expw(f, pg, r, 1'b0));
		rd(`DCL_REG_RDHI, q);
		chk("read high", q, expw(f, pg, r, 1'b1));
	endtask
	// =================================================================
	// scenarios
	task automatic t_reset();
		logic [31:0] q;
		logic        e;
		chk("reset outputs", {26'h0, rx_on, in_selfref, mpr_on, term_on, sr_rate}, 32'h20);
		rd(`DCL_REG_STAT, q);
		chk("stat reset", q, 32'h0);
		apb(1'b0, 8'h18, 32'h0, q, e);
		chk("unmapped", {31'h0, e}, 32'h1);
	endtask
	task automatic t_cal();
		logic [31:0] q;
		for (int l = 3; l <= `DCL_CAL_MAX; l += 4) begin
			issue(dcl_pkg::DCL_MRS, `DCL_MW_CAL, {5'h0, 3'(l), 6'h0});
			rd(`DCL_REG_STAT, q);
			chk("latency", {29'h0, q[4:2]}, 32'(l));
			chk("receivers asleep", {31'h0, rx_on}, 32'h0);
			t_read(dcl_pkg::DCL_RD, `DCL_FMT_STAG, 2'h0, 2'h2);
		end
		issue(dcl_pkg::DCL_MRS, `DCL_MW_CAL, 14'h0);
	endtask
	task automatic t_fmt();
		for (int f = 0; f < 4; f++)
			for (int r = 0; r < 4; r++)
				t_read(dcl_pkg::DCL_RD, 2'(f), 2'h0, 2'(r));
	endtask
	task automatic t_write();
		t_read(dcl_pkg::DCL_RDA, `DCL_FMT_PAR, `DCL_PAGE_RSVD, 2'h1);
		wr(`DCL_REG_WDATA, 32'h5a);
		issue(dcl_pkg::DCL_WR, 3'h0, 14'h0);
		issue(dcl_pkg::DCL_MRS, `DCL_MW_MPR, 14'h0004);
		wr(`DCL_REG_WDATA, 32'ha5);
		issue(dcl_pkg::DCL_WRA, 3'h1, 14'h0);
		pat[1] = 8'ha5;
		t_read(dcl_pkg::DCL_RD, `DCL_FMT_PAR, 2'h0, 2'h1);
		t_read(dcl_pkg::DCL_RDA, `DCL_FMT_PAR, 2'h0, 2'h0);
	endtask
	task automatic t_refuse();
		logic [31:0]        q;
		dcl_pkg::dcl_cmd_t  bad [4];
		bad = '{dcl_pkg::DCL_SRE, dcl_pkg::DCL_PDE, dcl_pkg::DCL_ACT, dcl_pkg::DCL_PRE};
		for (int i = 0; i < 4; i++) begin
			issue(bad[i], 3'h0, 14'h0);
			rd(`DCL_REG_STAT, q);
			chk("refused in store mode", {31'h0, q[1]}, 32'h1);
			wr(`DCL_REG_STAT, 32'h2);
		end
		chk("no self refresh", {31'h0, in_selfref}, 32'h0);
		issue(dcl_pkg::DCL_REF, 3'h0, 14'h0);
		rd(`DCL_REG_STAT, q);
		chk("refresh allowed", {31'h0, q[1]}, 32'h0);
		issue(dcl_pkg::DCL_MRS, `DCL_MW_MPR, 14'h0);
		chk("store off", {31'h0, mpr_on}, 32'h0);
	endtask
	task automatic t_dbi();
		logic [31:0] q;
		issue(dcl_pkg::DCL_MRS, `DCL_MW_DBI, 14'h1000);
		issue(dcl_pkg::DCL_MRS, `DCL_MW_MPR, 14'h0004);
		rd(`DCL_REG_STAT, q);
		chk("store with inversion", {30'h0, q[5], q[1]}, 32'h1);
		wr(`DCL_REG_STAT, 32'h2);
		issue(dcl_pkg::DCL_MRS, `DCL_MW_DBI, 14'h0);
	endtask
	task automatic t_sref();
		logic [31:0] q;
		logic [1:0]  want [4];
		want = '{`DCL_SRT_NORM, `DCL_SRT_RED, `DCL_SRT_EXT, `DCL_SRT_EXT};
		temp_hot_pin <= 1'b1;
		for (int m = 0; m < 4; m++) begin
			issue(dcl_pkg::DCL_MRS, `DCL_MW_SRT, {6'h0, 2'(m), 6'h0});
			issue(dcl_pkg::DCL_SRE, 3'h0, 14'h0);
			repeat (4) @(posedge clk);
			chk("in self refresh", {31'h0, in_selfref}, 32'h1);
			chk("rate", {30'h0, sr_rate}, {30'h0, want[m]});
			issue(dcl_pkg::DCL_MRS, `DCL_MW_SRT, 14'h0);
			rd(`DCL_REG_STAT, q);
			chk("mode change inside", {31'h0, q[1]}, 32'h1);
			wr(`DCL_REG_STAT, 32'h2);
			if (m == 3) begin
				temp_hot_pin <= 1'b0;
				temp_cold_pin <= 1'b1;
				repeat (6) @(posedge clk);
				chk("cold rate", {30'h0, sr_rate}, 32'h1);
			end
			issue(dcl_pkg::DCL_SRX, 3'h0, 14'h0);
			repeat (4) @(posedge clk);
			chk("rate after exit", {30'h0, sr_rate}, 32'h0);
		end
		temp_cold_pin <= 1'b0;
	endtask
	task automatic t_odt();
		wr(`DCL_REG_ODT, 32'h1);
		repeat (3) @(posedge clk);
		chk("termination", {30'h0, link.odt, term_on}, 32'h3);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// =================================================================
	// clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		num_errors++;
		summarize();
	end
	initial begin
		{rst, ce, psel, penable, pwrite, temp_hot_pin, temp_cold_pin} = 7'h60;
		paddr = 8'h00;
		pwdata = 32'h0;
		pat = '{`DCL_PAT0, `DCL_PAT1, `DCL_PAT2, `DCL_PAT3};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_cal();
		t_fmt();
		t_write();
		t_refuse();
		t_dbi();
		t_sref();
		t_odt();
		summarize();
	end
endmodule
